// >>> rtl/cfg_hdr_defs.vh
`ifndef CFG_HDR_DEFS_VH
`define CFG_HDR_DEFS_VH

// configuration dword indices (byte offset / 4)
`define DW_TENURE_LINE        6'h03
`define DW_CORE_WINDOW        6'h04
`define DW_EXT_WINDOW         6'h05

// byte offsets of the registers
`define OFS_TENURE_LINE       8'h0C
`define OFS_HEADER_SELFTEST   8'h0E
`define OFS_CORE_WINDOW       8'h10
`define OFS_EXT_WINDOW        8'h14

// field positions
`define LINE_LSB              0
`define LINE_MSB              7
`define TENURE_LSB            8
`define TENURE_MSB            15
`define CORE_PTR_LSB          11
`define EXT_PTR_LSB           14

// reset and constant read values
`define RST_TENURE            8'h00
`define RST_LINE              8'h00
`define RST_CORE_PTR          21'h000000
`define RST_EXT_PTR           18'h00000
`define SELF_TEST_FIELD       8'h00
`define HEADER_LAYOUT_FIELD   8'h00
`define CORE_LOW_BITS         11'h000
`define EXT_LOW_BITS          14'h0000

// bus commands that use the line length setting
`define CMD_MEM_READ_MULTIPLE 4'hC
`define CMD_MEM_READ_LINE     4'hE
`define CMD_MEM_WRITE_INVAL   4'hF

// tenure counter limits
`define TENURE_MAX            8'hFF

`endif

// >>> rtl/tenure_counter.v
`timescale 1ns/100ps
`include "cfg_hdr_defs.vh"

module tenure_counter (
  // clock and reset
  input  wire       clock_i,
  input  wire       sys_rst_i,
  // initiator status
  input  wire       frame_start_i,
  input  wire       xfer_active_i,
  input  wire       gnt_n_sync_i,
  input  wire [7:0] limit_i,
  // results
  output wire [7:0] count_o,
  output wire       expired_o,
  output wire       end_xfer_o
);

  reg       run_ff;
  reg [7:0] count_ff;
  reg       expired_ff;
  wire      expire_now;

  // limit reached: zero limit expires in the frame cycle itself
  assign expire_now = (frame_start_i && (limit_i == `RST_TENURE)) ||
                      (run_ff && (count_ff >= limit_i));

  // counter runs from zero in the frame cycle, one step per clock
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      run_ff     <= 1'b0;
      count_ff   <= 8'h00;
      expired_ff <= 1'b0;
    end else if (frame_start_i) begin
      run_ff     <= 1'b1;
      count_ff   <= 8'h01;
      expired_ff <= (limit_i == `RST_TENURE);
    end else if (run_ff && !xfer_active_i) begin
      run_ff     <= 1'b0;
      count_ff   <= 8'h00;
      expired_ff <= 1'b0;
    end else if (run_ff) begin
      if (count_ff != `TENURE_MAX)
        count_ff <= count_ff + 8'h01;
      if (expire_now)
        expired_ff <= 1'b1;
    end
  end

  assign count_o    = run_ff ? count_ff : 8'h00;
  assign expired_o  = expired_ff || expire_now;
  // end the tenure only once grant has gone away
  assign end_xfer_o = expired_o && xfer_active_i && gnt_n_sync_i;

endmodule

// >>> rtl/cfg_timer_header_bars.v
`timescale 1ns/100ps
`include "cfg_hdr_defs.vh"

// Overview of operation
// - bits 15 to 8 of the timer register hold a writable tenure limit in clocks.
// - as initiator the tenure counter starts at zero with frame and counts each clock.
// - once the limit is reached before the transfer ends, end it when grant drops.
// - bits 7 to 0 hold a writable line length used by line and invalidate commands.
// - the self test byte, bits 15 to 8 of the header register, reads as zero.
// - the header layout byte, bits 7 to 0, reads as zero for a single function.
// - writing all ones to the core window base reads back as FFFFF800.
// - core window base bits 31 to 11 are writable and hold the base address.
// - core window base bits 10 to 4 read zero and ignore writes.
// - core window base bits 3 to 0 read zero for a plain 32-bit memory window.
// - writing all ones to the extension window base reads back as FFFFC000.
// - extension window base bits 31 to 14 are writable and hold the base address.
// - extension window base bits 13 to 4 read zero and ignore writes.
// - extension window base bits 3 to 0 read zero for a plain 32-bit memory window.
// - reset clears the timer, header and both window base registers to zero.
module cfg_timer_header_bars (
  // clock and reset
  input  wire        clock_i,
  input  wire        sys_rst_i,
  // configuration access
  input  wire        cfg_wr_i,
  input  wire        cfg_rd_i,
  input  wire [5:0]  cfg_dw_i,
  input  wire [3:0]  cfg_be_i,
  input  wire [31:0] cfg_wdata_i,
  output wire        cfg_hit_o,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_done_o,
  // initiator side
  input  wire        frame_start_i,
  input  wire        xfer_active_i,
  input  wire [3:0]  xfer_cmd_i,
  input  wire        gnt_n_i,
  output reg  [7:0]  burst_len_o,
  output reg         line_cmd_o,
  output wire        tenure_expired_o,
  output wire        end_xfer_o,
  output reg  [7:0]  tenure_count_o,
  // target address decode
  input  wire [31:0] mem_addr_i,
  input  wire        mem_addr_valid_i,
  output reg         core_window_hit_o,
  output reg         ext_window_hit_o,
  // programmed settings
  output reg  [7:0]  tenure_limit_o,
  output reg  [7:0]  line_length_setting_o,
  output reg  [31:0] core_window_base_o,
  output reg  [31:0] ext_window_base_o
);

  // byte write helper: keep old byte unless its lane is enabled
  function [7:0] merge_byte;
    input [7:0] old_byte;
    input [7:0] new_byte;
    input       lane_en;
    begin
      merge_byte = lane_en ? new_byte : old_byte;
    end
  endfunction

  // commands that move whole cache lines
  function is_line_cmd;
    input [3:0] cmd;
    begin
      is_line_cmd = (cmd == `CMD_MEM_READ_MULTIPLE) ||
                    (cmd == `CMD_MEM_READ_LINE) ||
                    (cmd == `CMD_MEM_WRITE_INVAL);
    end
  endfunction

  // settings held by software
  reg  [7:0]  tenure_limit_ff;
  reg  [7:0]  line_length_setting_ff;
  reg  [20:0] core_window_pointer_ff;
  reg  [17:0] ext_window_pointer_ff;

  // grant pin synchroniser
  reg         gnt_n_meta_ff;
  reg         gnt_n_sync_ff;

  // access decode
  wire        hit_tenure;
  wire        hit_core;
  wire        hit_ext;
  wire        wr_tenure;
  wire        wr_core;
  wire        wr_ext;

  // next values
  reg  [7:0]  nxt_tenure_limit;
  reg  [7:0]  nxt_line_length;
  reg  [20:0] nxt_core_ptr;
  reg  [17:0] nxt_ext_ptr;
  reg  [31:0] nxt_rdata;

  // full register images as read by software
  wire [15:0] tenure_line_word;
  wire [15:0] header_selftest_word;
  wire [31:0] core_window_word;
  wire [31:0] ext_window_word;
  wire [31:0] core_merged;
  wire [31:0] ext_merged;

  // tenure counter results
  wire [7:0]  count_w;

  // dword decode of the three claimed locations
  assign hit_tenure = (cfg_dw_i == `DW_TENURE_LINE);
  assign hit_core   = (cfg_dw_i == `DW_CORE_WINDOW);
  assign hit_ext    = (cfg_dw_i == `DW_EXT_WINDOW);
  assign cfg_hit_o  = hit_tenure || hit_core || hit_ext;

  assign wr_tenure  = cfg_wr_i && hit_tenure;
  assign wr_core    = cfg_wr_i && hit_core;
  assign wr_ext     = cfg_wr_i && hit_ext;

  // register images; fixed fields are constants
  assign tenure_line_word     = {tenure_limit_ff, line_length_setting_ff};
  assign header_selftest_word = {`SELF_TEST_FIELD, `HEADER_LAYOUT_FIELD};
  assign core_window_word     = {core_window_pointer_ff, `CORE_LOW_BITS};
  assign ext_window_word      = {ext_window_pointer_ff, `EXT_LOW_BITS};

  // written dword after byte lane merge
  assign core_merged = {merge_byte(core_window_word[31:24], cfg_wdata_i[31:24], cfg_be_i[3]),
                        merge_byte(core_window_word[23:16], cfg_wdata_i[23:16], cfg_be_i[2]),
                        merge_byte(core_window_word[15:8], cfg_wdata_i[15:8], cfg_be_i[1]),
                        merge_byte(core_window_word[7:0], cfg_wdata_i[7:0], cfg_be_i[0])};
  assign ext_merged  = {merge_byte(ext_window_word[31:24], cfg_wdata_i[31:24], cfg_be_i[3]),
                        merge_byte(ext_window_word[23:16], cfg_wdata_i[23:16], cfg_be_i[2]),
                        merge_byte(ext_window_word[15:8], cfg_wdata_i[15:8], cfg_be_i[1]),
                        merge_byte(ext_window_word[7:0], cfg_wdata_i[7:0], cfg_be_i[0])};

  // next state of the writable fields
  always @* begin
    nxt_tenure_limit = tenure_limit_ff;
    nxt_line_length  = line_length_setting_ff;
    nxt_core_ptr     = core_window_pointer_ff;
    nxt_ext_ptr      = ext_window_pointer_ff;
    if (wr_tenure) begin
      nxt_line_length  = merge_byte(line_length_setting_ff, cfg_wdata_i[7:0],
                                    cfg_be_i[0]);
      nxt_tenure_limit = merge_byte(tenure_limit_ff, cfg_wdata_i[15:8],
                                    cfg_be_i[1]);
      // lanes 2 and 3 hit the read-only header byte pair: dropped
    end
    if (wr_core)
      nxt_core_ptr = core_merged[31:`CORE_PTR_LSB];
    if (wr_ext)
      nxt_ext_ptr = ext_merged[31:`EXT_PTR_LSB];
  end

  // setting registers
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      tenure_limit_ff        <= `RST_TENURE;
      line_length_setting_ff <= `RST_LINE;
      core_window_pointer_ff <= `RST_CORE_PTR;
      ext_window_pointer_ff  <= `RST_EXT_PTR;
    end else begin
      tenure_limit_ff        <= nxt_tenure_limit;
      line_length_setting_ff <= nxt_line_length;
      core_window_pointer_ff <= nxt_core_ptr;
      ext_window_pointer_ff  <= nxt_ext_ptr;
    end
  end

  // read data mux; unclaimed dwords read zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (cfg_dw_i)
      `DW_TENURE_LINE: nxt_rdata = {header_selftest_word, tenure_line_word};
      `DW_CORE_WINDOW: nxt_rdata = core_window_word;
      `DW_EXT_WINDOW:  nxt_rdata = ext_window_word;
      default:         nxt_rdata = 32'h00000000;
    endcase
  end

  // registered answer one clock after the access
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= 32'h00000000;
      cfg_done_o  <= 1'b0;
    end else begin
      cfg_done_o <= cfg_rd_i || cfg_wr_i;
      if (cfg_rd_i)
        cfg_rdata_o <= nxt_rdata;
    end
  end

  // grant comes from the arbiter pin: two stages
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      gnt_n_meta_ff <= 1'b1;
      gnt_n_sync_ff <= 1'b1;
    end else begin
      gnt_n_meta_ff <= gnt_n_i;
      gnt_n_sync_ff <= gnt_n_meta_ff;
    end
  end

  // bus tenure tracking for initiated transfers
  tenure_counter u_tenure (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .frame_start_i (frame_start_i),
    .xfer_active_i (xfer_active_i),
    .gnt_n_sync_i  (gnt_n_sync_ff),
    .limit_i       (tenure_limit_ff),
    .count_o       (count_w),
    .expired_o     (tenure_expired_o),
    .end_xfer_o    (end_xfer_o)
  );

  // burst length for the current initiator command
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      burst_len_o    <= 8'h00;
      line_cmd_o     <= 1'b0;
      tenure_count_o <= 8'h00;
    end else begin
      tenure_count_o <= count_w;
      line_cmd_o     <= is_line_cmd(xfer_cmd_i);
      if (is_line_cmd(xfer_cmd_i))
        burst_len_o <= line_length_setting_ff;
      else
        burst_len_o <= 8'h01;
    end
  end

  // memory window decode against the programmed bases
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      core_window_hit_o <= 1'b0;
      ext_window_hit_o  <= 1'b0;
    end else begin
      core_window_hit_o <= mem_addr_valid_i &&
                           (mem_addr_i[31:`CORE_PTR_LSB] == core_window_pointer_ff);
      ext_window_hit_o  <= mem_addr_valid_i &&
                           (mem_addr_i[31:`EXT_PTR_LSB] == ext_window_pointer_ff);
    end
  end

  // settings mirrored for the rest of the function
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      tenure_limit_o        <= `RST_TENURE;
      line_length_setting_o <= `RST_LINE;
      core_window_base_o    <= 32'h00000000;
      ext_window_base_o     <= 32'h00000000;
    end else begin
      tenure_limit_o        <= tenure_limit_ff;
      line_length_setting_o <= line_length_setting_ff;
      core_window_base_o    <= core_window_word;
      ext_window_base_o     <= ext_window_word;
    end
  end

endmodule

// >>> verification/grant_arbiter_model.sv
`timescale 1ns/100ps
// bus arbiter stand-in: grant parked until revoked, removed after a delay
module grant_arbiter_model (
  // clock and reset
  input  wire       clock_i,
  input  wire       sys_rst_i,
  // control from the bench
  input  wire [3:0] hold_i,
  input  wire       revoke_i,
  // grant pin, active low
  output reg        gnt_n_o
);
  reg [3:0] wait_ff;

  // grant held until revoke, then dropped on the clock edge hold_i + 1 after revoke rises
  always @(posedge clock_i) begin
    if (sys_rst_i || !revoke_i) begin
      wait_ff <= 4'h0;
      gnt_n_o <= sys_rst_i;
    end else if (wait_ff >= hold_i) begin
      gnt_n_o <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// >>> verification/cfg_hdr_props.sv
`timescale 1ns/100ps
// timing and value relations at the header bank ports
module cfg_hdr_props (
  // clock and reset
  input wire        clock_i,
  input wire        sys_rst_i,
  // config access
  input wire        cfg_wr_i,
  input wire        cfg_rd_i,
  input wire [5:0]  cfg_dw_i,
  input wire [31:0] cfg_rdata_o,
  input wire        cfg_done_o,
  // initiator side
  input wire        frame_start_i,
  input wire        xfer_active_i,
  input wire [3:0]  xfer_cmd_i,
  input wire        gnt_n_i,
  input wire [7:0]  burst_len_o,
  input wire        tenure_expired_o,
  input wire        end_xfer_o,
  input wire [7:0]  tenure_count_o,
  // programmed settings
  input wire [7:0]  tenure_limit_o,
  input wire [7:0]  line_length_setting_o,
  input wire [31:0] core_window_base_o,
  input wire [31:0] ext_window_base_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // config handshake and read-back
  a_done_pulse: assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_done_o)
    else $error("done pulse missing");
  a_core_readback: assert property (cfg_rd_i && cfg_dw_i == 6'h04 |=>
    cfg_rdata_o == core_window_base_o && cfg_rdata_o[10:0] == 11'h000) else $error("core base");
  a_ext_readback: assert property (cfg_rd_i && cfg_dw_i == 6'h05 |=>
    cfg_rdata_o == ext_window_base_o && cfg_rdata_o[13:0] == 14'h0000) else $error("ext base");
  a_header_zero: assert property (cfg_rd_i && cfg_dw_i == 6'h03 |=>
    cfg_rdata_o == {16'h0000, tenure_limit_o, line_length_setting_o}) else $error("timer dword");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst_i ##1 sys_rst_i |=>
    {tenure_limit_o, line_length_setting_o, core_window_base_o, ext_window_base_o} == 80'h0)
    else $error("reset values");
  // tenure counting and ending
  a_count_step: assert property (frame_start_i ##1 (!frame_start_i)[*3] |=>
    tenure_count_o == 8'h03) else $error("tenure count");
  a_end_cause: assert property (end_xfer_o |-> tenure_expired_o && xfer_active_i)
    else $error("end without expiry");
  a_end_on_grant: assert property (tenure_expired_o && xfer_active_i && gnt_n_i &&
    $past(gnt_n_i) && $past(gnt_n_i, 2) |-> end_xfer_o) else $error("end missing");
  a_line_burst: assert property (xfer_cmd_i inside {4'hC, 4'hE, 4'hF} |=>
    burst_len_o == line_length_setting_o) else $error("line burst length");
  // main scenarios
  c_end: cover property (frame_start_i ##[1:300] end_xfer_o);
  c_core_wr: cover property (cfg_wr_i && cfg_dw_i == 6'h04);
  c_ext_rd: cover property (cfg_rd_i && cfg_dw_i == 6'h05);
endmodule

bind cfg_timer_header_bars cfg_hdr_props u_props (.clock_i, .sys_rst_i, .cfg_wr_i, .cfg_rd_i,
  .cfg_dw_i, .cfg_rdata_o, .cfg_done_o, .frame_start_i, .xfer_active_i, .xfer_cmd_i, .gnt_n_i,
  .burst_len_o, .tenure_expired_o, .end_xfer_o, .tenure_count_o, .tenure_limit_o,
  .line_length_setting_o, .core_window_base_o, .ext_window_base_o);

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  // stimulus, model and bookkeeping
  reg         clock_i, sys_rst_i, cfg_wr_i, cfg_rd_i, frame_start_i, xfer_active_i;
  reg         mem_addr_valid_i, revoke;
  reg  [5:0]  cfg_dw_i;
  reg  [3:0]  cfg_be_i, xfer_cmd_i, hold;
  reg  [31:0] cfg_wdata_i, mem_addr_i, r;
  reg  [31:0] mdl [0:63];
  reg  [7:0]  lim;
  integer     seed, fail_count, check_count, i, j, k;
  wire        gnt_n_i, cfg_hit_o, cfg_done_o, line_cmd_o, tenure_expired_o, end_xfer_o;
  wire        core_window_hit_o, ext_window_hit_o;
  wire [31:0] cfg_rdata_o, core_window_base_o, ext_window_base_o;
  wire [7:0]  burst_len_o, tenure_count_o, tenure_limit_o, line_length_setting_o;

  cfg_timer_header_bars DUT (.clock_i, .sys_rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_dw_i, .cfg_be_i,
    .cfg_wdata_i, .cfg_hit_o, .cfg_rdata_o, .cfg_done_o, .frame_start_i, .xfer_active_i,
    .xfer_cmd_i, .gnt_n_i, .burst_len_o, .line_cmd_o, .tenure_expired_o, .end_xfer_o,
    .tenure_count_o, .mem_addr_i, .mem_addr_valid_i, .core_window_hit_o, .ext_window_hit_o,
    .tenure_limit_o, .line_length_setting_o, .core_window_base_o, .ext_window_base_o);
  grant_arbiter_model u_arb (.clock_i, .sys_rst_i, .hold_i(hold), .revoke_i(revoke),
    .gnt_n_o(gnt_n_i));

  // clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // compare and count
  task check(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // writable bits of each dword
  function [31:0] wmask(input [5:0] dw);
    wmask = dw == 6'h03 ? 32'h0000FFFF : dw == 6'h04 ? 32'hFFFFF800 :
            dw == 6'h05 ? 32'hFFFFC000 : 32'h0;
  endfunction

  // one config access; strobe left up for back-to-back use
  task cfg_access(input wr, input [5:0] dw, input [3:0] be, input [31:0] data);
    reg [31:0] m;
    cfg_wr_i = wr;
    cfg_rd_i = !wr;
    cfg_dw_i = dw;
    cfg_be_i = be;
    cfg_wdata_i = data;
    @(posedge clock_i);
    #1;
    check(cfg_done_o, 1'b1);
    check(cfg_hit_o, dw >= 6'h03 && dw <= 6'h05);
    m = wmask(dw) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (wr) mdl[dw] = (mdl[dw] & ~m) | (data & m);
    else check(cfg_rdata_o, mdl[dw]);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end

  // main sequence
  initial begin
    seed = 84;
    fail_count = 0;
    check_count = 0;
    {cfg_wr_i, cfg_rd_i, frame_start_i, xfer_active_i, mem_addr_valid_i, revoke} = 6'h00;
    {cfg_dw_i, cfg_be_i, xfer_cmd_i, hold, cfg_wdata_i, mem_addr_i} = 82'h0;
    for (i = 0; i < 64; i++) mdl[i] = 32'h0;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    for (i = 2; i < 7; i++) cfg_access(1'b0, i[5:0], 4'h0, 32'h0);
    for (i = 2; i < 7; i++) begin
      cfg_access(1'b1, i[5:0], 4'hF, 32'hFFFFFFFF);
      cfg_access(1'b0, i[5:0], 4'h0, 32'h0);
    end
    repeat (60) begin
      r = $random(seed);
      cfg_access(r[0], 6'h02 + {4'h0, r[2:1]}, r[6:3], $random(seed));
    end
    cfg_rd_i = 1'b0;
    cfg_wr_i = 1'b0;
    for (i = 0; i < 16; i++) begin
      xfer_cmd_i = i[3:0];
      @(posedge clock_i);
      #1;
      check(line_cmd_o, i == 12 || i >= 14);
      check(burst_len_o, (i == 12 || i >= 14) ? mdl[3][7:0] : 8'h01);
    end
    // mirrored settings follow the programmed registers
    check(tenure_limit_o, mdl[3][15:8]);
    check(line_length_setting_o, mdl[3][7:0]);
    check(core_window_base_o, mdl[4]);
    check(ext_window_base_o, mdl[5]);
    for (j = 0; j < 3; j++) begin
      r = $random(seed);
      lim = j == 0 ? 8'h00 : j == 1 ? 8'h03 : {5'h00, r[2:0]} + 8'h01;
      hold = {2'h0, r[5:4]};
      cfg_access(1'b1, 6'h03, 4'h2, {16'h0, lim, 8'h00});
      cfg_wr_i = 1'b0;
      frame_start_i = 1'b1;
      xfer_active_i = 1'b1;
      for (k = 0; k < lim + 3; k++) begin
        #19;
        check(tenure_expired_o, k >= lim);
        check(end_xfer_o, 1'b0);
        if (k > 0) check(tenure_count_o, k - 1);
        @(posedge clock_i);
        #1 frame_start_i = 1'b0;
      end
      revoke = 1'b1;
      for (k = 0; k < 12 && end_xfer_o !== 1'b1; k++) begin
        @(posedge clock_i);
        #1;
      end
      check(end_xfer_o, 1'b1);
      xfer_active_i = 1'b0;
      revoke = 1'b0;
      @(posedge clock_i);
      #1;
      check(tenure_expired_o, 1'b0);
      repeat (4) @(posedge clock_i);
      #1;
    end
    repeat (40) begin
      r = $random(seed);
      mem_addr_valid_i = r[31];
      mem_addr_i = r[1:0] == 2'h0 ? mdl[4] ^ {21'h0, r[12:2]} :
                   r[1:0] == 2'h1 ? mdl[5] ^ {18'h0, r[15:2]} : $random(seed);
      @(posedge clock_i);
      #1;
      check(core_window_hit_o, r[31] && mem_addr_i[31:11] == mdl[4][31:11]);
      check(ext_window_hit_o, r[31] && mem_addr_i[31:14] == mdl[5][31:14]);
    end
    // reset in mid-run clears every setting again
    mem_addr_valid_i = 1'b0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    for (i = 0; i < 64; i++) mdl[i] = 32'h0;
    check(tenure_limit_o, 8'h00);
    check(line_length_setting_o, 8'h00);
    check(core_window_base_o, 32'h00000000);
    check(ext_window_base_o, 32'h00000000);
    for (i = 3; i < 6; i++) cfg_access(1'b0, i[5:0], 4'h0, 32'h0);
    end_sim;
  end
endmodule
